// ==== rtl/owd_pkg.sv ====
// Constants shared by the one-wire dimming command receiver
package owd_pkg;

  // ----------------------------------------------------------------
  // Clock and link timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 10;
  localparam int unsigned T_VALACK_NS    = 2000;     // Delay before acknowledge
  localparam int unsigned T_ACKN_NS      = 512000;   // Longest acknowledge pulse
  localparam int unsigned T_SHUTDOWN_NS  = 2500000;  // Least low time that shuts down
  localparam int unsigned T_BIT_MAX_NS   = 600000;   // Bit phase longer than this aborts
  localparam int unsigned VALACK_CYC     = (T_VALACK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ACKN_CYC       = (T_ACKN_NS * CLK_MHZ) / 1000;
  localparam int unsigned SHUTDOWN_CYC   = (T_SHUTDOWN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BIT_MAX_CYC    = (T_BIT_MAX_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Command layout
  // ----------------------------------------------------------------
  localparam int unsigned CMD_BITS       = 24;
  localparam int unsigned ADDR_MSB       = 23;
  localparam int unsigned ADDR_LSB       = 16;
  localparam int unsigned ACK_REQ_POS    = 10;
  localparam int unsigned BRIGHT_MSB     = 8;
  localparam int unsigned BRIGHT_LSB     = 0;
  localparam logic [7:0]  DEV_ADDR       = 8'h8F;
  localparam logic [8:0]  BRIGHT_RESET   = 9'h1FF;
  localparam int unsigned RATIO          = 2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL       = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam logic [3:0]  REG_LAST_CMD   = 4'h8;
  localparam logic [3:0]  REG_COUNTS     = 4'hC;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_DECERR    = 2'h3;
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam logic        CTRL_EN_RESET  = 1'b1;

  // ----------------------------------------------------------------
  // Receiver states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OWD_RX,
    OWD_VALWAIT,
    OWD_ACK
  } owd_state_t;

endpackage

// ==== rtl/owd_bit_timer.sv ====
// Bit timing of the one-wire line: high/low phase measurement and decode
`timescale 1ns/10ps
`default_nettype none
module owd_bit_timer
  import owd_pkg::*;
#(
  parameter int unsigned CNT_W    = 16,
  parameter int unsigned BIT_MAX  = BIT_MAX_CYC,
  parameter int unsigned SHUTDOWN = SHUTDOWN_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic line_in,
  input  wire logic clr,
  output logic      bit_stb_q,
  output logic      bit_val_q,
  output logic      bit_err_q,
  output logic      abort_q,
  output logic      shutdown_q
);

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] LIM_BIT = CNT_W'(BIT_MAX);
  localparam logic [CNT_W-1:0] LIM_SHD = CNT_W'(SHUTDOWN);

  logic             line_q;
  logic             in_bit_q;
  logic [CNT_W-1:0] hi_q;
  logic [CNT_W-1:0] lo_q;
  logic [CNT_W-1:0] low_run_q;

  // ----------------------------------------------------------------
  // Edge and ratio decode
  // ----------------------------------------------------------------
  wire logic         fall    = line_q & ~line_in;
  wire logic [CNT_W:0] hi2   = {hi_q, 1'b0};
  wire logic [CNT_W:0] lo2   = {lo_q, 1'b0};
  wire logic         is_zero = ({1'b0, lo_q} >= hi2) && (hi_q != '0);
  wire logic         is_one  = ({1'b0, hi_q} >= lo2) && (lo_q != '0);
  wire logic         too_long = in_bit_q && (line_in ? (hi_q >= LIM_BIT) : (lo_q >= LIM_BIT));

  // Line sample and bit window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_q   <= 1'b1;
      in_bit_q <= 1'b0;
    end else begin
      line_q   <= line_in;
      in_bit_q <= clr || too_long ? 1'b0 : (fall ? 1'b1 : in_bit_q);
    end
  end

  // Phase counters, restarted at each falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn || fall) begin
      hi_q <= '0;
      lo_q <= {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (line_in) begin
      hi_q <= (hi_q == CNT_MAX) ? hi_q : hi_q + 1'b1;
    end else begin
      lo_q <= (lo_q == CNT_MAX) ? lo_q : lo_q + 1'b1;
    end
  end

  // Bit closes at the next falling edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_stb_q <= 1'b0;
      bit_val_q <= 1'b0;
      bit_err_q <= 1'b0;
      abort_q   <= 1'b0;
    end else begin
      bit_stb_q <= fall && in_bit_q && !clr;
      bit_val_q <= is_one;
      bit_err_q <= !(is_zero || is_one);
      abort_q   <= too_long && !clr;
    end
  end

  // Long low level shuts the device down
  always_ff @(posedge aclk) begin
    if (!aresetn || line_in) begin
      low_run_q  <= '0;
      shutdown_q <= 1'b0;
    end else begin
      low_run_q  <= (low_run_q == CNT_MAX) ? low_run_q : low_run_q + 1'b1;
      shutdown_q <= (low_run_q >= LIM_SHD);
    end
  end

endmodule
`default_nettype wire

// ==== rtl/owd_rx.sv ====
// One-wire dimming command receiver with AXI4-Lite status and control
`timescale 1ns/10ps
`default_nettype none
module owd_rx
  import owd_pkg::*;
#(
  parameter int unsigned CNT_W    = 16,
  parameter int unsigned ACK_LEN  = ACKN_CYC,
  parameter int unsigned BIT_MAX  = BIT_MAX_CYC,
  parameter int unsigned SHUTDOWN = SHUTDOWN_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        line_in,
  output logic             line_out,
  output logic             line_oe,
  output logic [8:0]       brightness_code
);

  localparam logic [CNT_W-1:0] VAL_LIM = CNT_W'(VALACK_CYC);
  localparam logic [CNT_W-1:0] ACK_LIM = CNT_W'(ACK_LEN);
  localparam logic [4:0]       LAST_BIT = 5'(CMD_BITS - 1);

  owd_state_t       state_q;
  logic [CNT_W-1:0] tmr_q;
  logic [4:0]       bit_cnt_q;
  logic [23:0]      shreg_q;
  logic [23:0]      last_cmd_q;
  logic [15:0]      good_cnt_q;
  logic [15:0]      bad_cnt_q;
  logic             enable_q;
  logic             aw_held_q;
  logic             w_held_q;
  logic [3:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             bit_stb;
  logic             bit_val;
  logic             bit_err;
  logic             abort;
  logic             shutdown;

  // ----------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------
  wire logic active   = enable_q && !shutdown;
  wire logic tmr_clr  = !active || (state_q != OWD_RX);

  owd_bit_timer #(
    .CNT_W    (CNT_W),
    .BIT_MAX  (BIT_MAX),
    .SHUTDOWN (SHUTDOWN)
  ) u_timer (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .line_in    (line_in),
    .clr        (tmr_clr),
    .bit_stb_q  (bit_stb),
    .bit_val_q  (bit_val),
    .bit_err_q  (bit_err),
    .abort_q    (abort),
    .shutdown_q (shutdown)
  );

  // ----------------------------------------------------------------
  // Frame decode
  // ----------------------------------------------------------------
  // New bit enters at the top so the last bit ends up as bit 23
  wire logic [23:0] cmd_next   = {bit_val, shreg_q[23:1]};
  wire logic        good_bit   = bit_stb && !bit_err;
  wire logic        frame_done = good_bit && (bit_cnt_q == LAST_BIT);
  wire logic        addr_ok    = cmd_next[ADDR_MSB:ADDR_LSB] == DEV_ADDR;
  wire logic        ack_req    = cmd_next[ACK_REQ_POS];
  wire logic        frame_ok   = frame_done && addr_ok;
  wire logic        frame_bad  = (frame_done && !addr_ok) || (bit_stb && bit_err) ||
                                 (abort && bit_cnt_q != '0);
  wire logic        tmr_end    = (state_q == OWD_VALWAIT) ? (tmr_q >= VAL_LIM - 1'b1)
                                                          : (tmr_q >= ACK_LIM - 1'b1);

  // Shift register and bit counter
  always_ff @(posedge aclk) begin
    if (!aresetn || tmr_clr || abort || (bit_stb && bit_err) || frame_done) begin
      bit_cnt_q <= '0;
    end else if (good_bit) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shreg_q <= '0;
    end else if (good_bit) begin
      shreg_q <= cmd_next;
    end
  end

  // Brightness register and frame log
  always_ff @(posedge aclk) begin
    if (!aresetn || !active) begin
      brightness_code <= BRIGHT_RESET;
    end else if (frame_ok) begin
      brightness_code <= cmd_next[BRIGHT_MSB:BRIGHT_LSB];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_cmd_q <= '0;
      good_cnt_q <= '0;
      bad_cnt_q  <= '0;
    end else begin
      last_cmd_q <= frame_done ? cmd_next : last_cmd_q;
      good_cnt_q <= good_cnt_q + 16'(frame_ok);
      bad_cnt_q  <= bad_cnt_q + 16'(frame_bad && active);
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge sequence
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !active) begin
      state_q <= OWD_RX;
      tmr_q   <= '0;
    end else begin
      tmr_q <= tmr_q + 1'b1;
      case (state_q)
        OWD_RX: begin
          tmr_q <= '0;
          if (frame_ok && ack_req) begin
            state_q <= OWD_VALWAIT;
          end
        end
        OWD_VALWAIT: begin
          if (tmr_end) begin
            state_q <= OWD_ACK;
            tmr_q   <= '0;
          end
        end
        OWD_ACK: begin
          if (tmr_end) begin
            state_q <= OWD_RX;
          end
        end
        default: begin
          state_q <= OWD_RX;
        end
      endcase
    end
  end

  // Pull-down switch: the only thing driven onto the line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_out <= 1'b0;
      line_oe  <= 1'b0;
    end else begin
      line_out <= 1'b0;
      line_oe  <= active && (state_q == OWD_VALWAIT) && tmr_end ||
                  active && (state_q == OWD_ACK) && !tmr_end;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  wire logic aw_hs   = s_axi_awvalid && s_axi_awready;
  wire logic w_hs    = s_axi_wvalid && s_axi_wready;
  wire logic both    = aw_held_q && w_held_q && !s_axi_bvalid;
  wire logic wr_ctrl = both && (awaddr_q == REG_CTRL) && wstrb_q[0];
  wire logic wr_map  = (awaddr_q == REG_CTRL) || (awaddr_q == REG_STATUS) ||
                       (awaddr_q == REG_LAST_CMD) || (awaddr_q == REG_COUNTS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end else begin
      aw_held_q <= both ? 1'b0 : (aw_hs ? 1'b1 : aw_held_q);
      w_held_q  <= both ? 1'b0 : (w_hs ? 1'b1 : w_held_q);
      awaddr_q  <= aw_hs ? {s_axi_awaddr[3:2], 2'b00} : awaddr_q;
      wdata_q   <= w_hs ? s_axi_wdata : wdata_q;
      wstrb_q   <= w_hs ? s_axi_wstrb : wstrb_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      enable_q      <= CTRL_EN_RESET;
    end else begin
      s_axi_awready <= !aw_held_q && !aw_hs && !s_axi_bvalid;
      s_axi_wready  <= !w_held_q && !w_hs && !s_axi_bvalid;
      s_axi_bvalid  <= both ? 1'b1 : (s_axi_bready ? 1'b0 : s_axi_bvalid);
      s_axi_bresp   <= both ? (wr_map ? RESP_OKAY : RESP_DECERR) : s_axi_bresp;
      enable_q      <= wr_ctrl ? wdata_q[CTRL_EN_BIT] : enable_q;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  wire logic        ar_hs   = s_axi_arvalid && s_axi_arready;
  wire logic [3:0]  raddr   = {s_axi_araddr[3:2], 2'b00};
  wire logic [31:0] status  = {20'h0_0000, shutdown, (state_q != OWD_RX),
                               (bit_cnt_q != '0), brightness_code};
  wire logic        rd_map  = (raddr == REG_CTRL) || (raddr == REG_STATUS) ||
                              (raddr == REG_LAST_CMD) || (raddr == REG_COUNTS);
  wire logic [31:0] rd_mux  = (raddr == REG_CTRL)     ? {31'h0000_0000, enable_q} :
                              (raddr == REG_STATUS)   ? status :
                              (raddr == REG_LAST_CMD) ? {8'h00, last_cmd_q} :
                              (raddr == REG_COUNTS)   ? {bad_cnt_q, good_cnt_q} :
                              32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_hs;
      s_axi_rvalid  <= ar_hs ? 1'b1 : (s_axi_rready ? 1'b0 : s_axi_rvalid);
      s_axi_rdata   <= ar_hs ? rd_mux : s_axi_rdata;
      s_axi_rresp   <= ar_hs ? (rd_map ? RESP_OKAY : RESP_DECERR) : s_axi_rresp;
    end
  end

endmodule
`default_nettype wire

// ==== sim/owd_rx_assertions.sv ====
// Concurrent checks on the ports of the one-wire dimming command receiver
`timescale 1ns/10ps
`default_nettype none
module owd_rx_assertions
  import owd_pkg::*;
#(
  parameter int unsigned ACK_LEN  = ACKN_CYC,
  parameter int unsigned SHUTDOWN = SHUTDOWN_CYC
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        line_in,
  input wire logic        line_out,
  input wire logic        line_oe,
  input wire logic [8:0]  brightness_code
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------------------------------
  // Helper counters: pull-down length, line low time
  // ----------------------------------------------------------------
  logic [15:0] oe_cnt_q;
  logic [15:0] low_cnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_cnt_q  <= '0;
      low_cnt_q <= '0;
    end else begin
      oe_cnt_q  <= line_oe ? oe_cnt_q + 16'h0001 : 16'h0000;
      low_cnt_q <= (!line_in && low_cnt_q != 16'hFFFF) ? low_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pull_only_low: assert property (line_out == 1'b0)
    else $error("line driven to a level other than low");
  a_ack_max_len: assert property (oe_cnt_q <= ACK_LEN)
    else $error("acknowledge pulse too long");
  a_ack_exact_len: assert property ($fell(line_oe) |-> oe_cnt_q == ACK_LEN)
    else $error("acknowledge pulse length wrong");
  a_ack_after_low: assert property ($rose(line_oe) |-> $past(line_in, 15) == 1'b0)
    else $error("acknowledge not after closing edge and delay");
  a_reset_code: assert property ($rose(aresetn) |-> brightness_code == BRIGHT_RESET)
    else $error("code not all ones after reset");
  a_shutdown_code: assert property (low_cnt_q > SHUTDOWN + 3 |-> brightness_code == 9'h1FF)
    else $error("code not all ones in shutdown");
  a_code_from_frame: assert property (($changed(brightness_code) && brightness_code != 9'h1FF)
    |-> !$past(line_in, 1) && !$past(line_in, 2))
    else $error("code changed outside a closing edge");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind owd_rx owd_rx_assertions #(.ACK_LEN(ACK_LEN), .SHUTDOWN(SHUTDOWN)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .line_in(line_in),
  .line_out(line_out), .line_oe(line_oe), .brightness_code(brightness_code));
`default_nettype wire

// ==== sim/owd_host_model.sv ====
// Open-drain host master that sends dimming commands on the one-wire line
`timescale 1ns/10ps
`default_nettype none
module owd_host_model (
  input  wire logic aclk,
  output logic      pull_low
);
  // Released at start; the pull-up holds the line high
  initial pull_low = 1'b0;
  // One line phase, changed just after a rising edge
  task automatic phase(input logic lvl, input int n);
    pull_low <= lvl;
    repeat (n) @(posedge aclk);
  endtask
  // Whole command, low first then high within each bit
  task automatic send(input logic [23:0] cmd, input int nbits, input int hold);
    int i;
    for (i = 0; i < nbits; i++) begin
      phase(1'b1, cmd[i] ? 10 : 30);
      phase(1'b0, cmd[i] ? 30 : 10);
    end
    phase(1'b1, hold); // Closing edge, held low through validation
    phase(1'b0, 1);
  endtask
endmodule
`default_nettype wire

// ==== sim/owd_rx_bench.sv ====
// Self-checking bench for the one-wire dimming command receiver
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module owd_rx_bench
  import owd_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, line_out, line_oe, host_low;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp;
  logic [8:0]  brightness_code;
  int          n_errors = 0;
  int          check_count = 0;
  wire logic   line_w = !(host_low | (line_oe & !line_out));
  always #50 aclk = ~aclk;
  owd_rx #(.CNT_W(16), .ACK_LEN(50), .BIT_MAX(200), .SHUTDOWN(400)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_in(line_w), .line_out(line_out), .line_oe(line_oe),
    .brightness_code(brightness_code));
  owd_host_model host_u (.aclk(aclk), .pull_low(host_low));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bound(input int n);
    if (n >= 300) begin
      n_errors++;
      $display("CHECK FAILED t=%0t wait ran out", $time);
      test_done();
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 300 && !(aw_ok && w_ok); n++) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (!w_ok && wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    bound(n);
    n = 0;
    do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 300);
    bound(n);
    `CHK(bresp, RESP_OKAY, "write response")
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 300);
    bound(n);
    arvalid <= 1'b0;
    n = 0;
    do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 300);
    bound(n);
    d = rdata;
    `CHK(rresp, RESP_OKAY, "read response")
    rready <= 1'b0;
  endtask
  // Command with zeros in the unused positions, closing low held for 30 cycles
  task automatic frame(input logic [7:0] a, input logic ack_request_flag, input logic [8:0] c, input int nb);
    host_u.send({a, 5'h00, ack_request_flag, 1'b0, c}, nb, 30);
  endtask
  task automatic idle();
    repeat (250) @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    `CHK(brightness_code, 9'h1FF, "code after reset")
    axi_rd(REG_STATUS, rd);
    `CHK(rd, 32'h0000_01FF, "status after reset")
  endtask
  task automatic t_good();
    frame(DEV_ADDR, 1'b0, 9'h0A5, 24);
    `CHK(brightness_code, 9'h0A5, "code from frame")
    axi_rd(REG_LAST_CMD, rd);
    `CHK(rd, 32'h008F_00A5, "frame bit order")
    idle();
  endtask
  task automatic t_bad();
    logic seen;
    seen = 1'b0;
    frame(8'h8E, 1'b1, 9'h033, 24);
    // Watch the pull-down for 60 cycles after the closing hold, past where an acknowledge would end
    repeat (60) begin
      @(posedge aclk);
      if (line_oe !== 1'b0) seen = 1'b1;
    end
    `CHK(brightness_code, 9'h0A5, "wrong address kept code")
    `CHK(seen, 1'b0, "no ack on wrong address")
    idle();
    frame(DEV_ADDR, 1'b0, 9'h033, 23);
    idle();
    `CHK(brightness_code, 9'h0A5, "short frame kept code")
  endtask
  task automatic t_ack();
    int n;
    frame(DEV_ADDR, 1'b1, 9'h10F, 24);
    `CHK(line_w, 1'b0, "line held low by ack")
    `CHK(brightness_code, 9'h10F, "code with ack request")
    axi_rd(REG_STATUS, rd);
    `CHK(rd, 32'h0000_050F, "ack busy in status")
    n = 0;
    while (line_oe !== 1'b0 && n < 300) begin @(posedge aclk); n++; end
    bound(n);
    `CHK(line_w, 1'b1, "line released after ack")
    idle();
  endtask
  task automatic t_ctrl();
    axi_wr(REG_STATUS, 32'h0000_0000);
    axi_rd(REG_STATUS, rd);
    `CHK(rd[8:0], 9'h10F, "read-only status kept")
    axi_rd(REG_COUNTS, rd);
    `CHK(rd, 32'h0002_0002, "good and bad frame counts")
    axi_wr(REG_CTRL, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    `CHK(brightness_code, 9'h1FF, "code after disable")
    axi_wr(REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge aclk);
  endtask
  task automatic t_shut();
    frame(DEV_ADDR, 1'b0, 9'h055, 24);
    `CHK(brightness_code, 9'h055, "code after enable")
    idle();
    host_u.phase(1'b1, 450);
    host_u.phase(1'b0, 5);
    `CHK(brightness_code, 9'h1FF, "code after shutdown")
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0; wdata = 32'h0000_0000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset();
    t_good();
    t_bad();
    t_ack();
    t_ctrl();
    t_shut();
    test_done();
  end
endmodule
`default_nettype wire
